// *** verif/tdm_i2s_audio_port_tb_top.sv ***
// Self-checking bench of the shared audio port against a far-side converter model.
`timescale 1ns/1ps
`default_nettype none
module tdm_i2s_audio_port_tb_top;
   import tia_pkg::*;
   logic clk_sys = 1'b0, clk_link = 1'b0, srst = 1'b1, device_rst_n = 1'b1;
   tia_cfg_type cfg = CFG_RESET;
   tia_frame_type tx_frame = '0, rx_frame;
   // The far side runs its bit clock through power-up reset so that the link
   // logic, which only resets on bit clock edges, starts from known state.
   logic tx_valid = 1'b0, tx_ready, rx_valid, run = 1'b1, echo = 1'b0;
   logic bclk_drv, bclk_oe, frame_pulse_drv, frame_pulse_oe, pcm_tx_data, pcm_tx_data_oe;
   logic bclk_out, fs_line, sdi, bclk_pin, fs_pin;
   logic [31:0] src = 32'h0, got;
   int mismatches = 0, checks_done = 0, cycles = 0;
   assign bclk_pin = bclk_oe ? bclk_drv : bclk_out;
   assign fs_pin = frame_pulse_oe ? frame_pulse_drv : fs_line;
   tia_audio_port #(.BCLK_HALF_CYC(2)) tia_audio_port_i (
      .clk_sys(clk_sys), .srst(srst), .device_rst_n(device_rst_n), .cfg(cfg),
      .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_frame(rx_frame), .rx_valid(rx_valid), .bclk(bclk_pin), .bclk_drv(bclk_drv),
      .bclk_oe(bclk_oe), .frame_pulse(fs_pin), .frame_pulse_drv(frame_pulse_drv),
      .frame_pulse_oe(frame_pulse_oe), .pcm_rx_data(echo ? pcm_tx_data : sdi),
      .pcm_tx_data(pcm_tx_data), .pcm_tx_data_oe(pcm_tx_data_oe));
   tia_far_end tia_far_end_i (
      .clk_link(clk_link), .run(run), .fmt_pcm(cfg.fmt == TIA_FMT_PCM), .src(src),
      .bclk_pin(bclk_pin), .dev_sdo(pcm_tx_data), .bclk_out(bclk_out),
      .fs_line(fs_line), .sdi(sdi), .got(got));
   initial forever #20 clk_sys = ~clk_sys;
   // The link clock is offset so its edges never line up with the system clock.
   initial begin
      #3;
      forever #7.5 clk_link = ~clk_link;
   end
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // The word and valid stay put until the edge at which ready is seen high.
   task automatic send(input logic [31:0] w);
      logic ok;
      ok = 1'b0;
      tx_frame = w;
      tx_valid = 1'b1;
      for (int i = 0; i < 400 && !ok; i++) begin
         ok = (tx_ready === 1'b1);
         tick(1);
      end
      tx_valid = 1'b0;
      check(ok, 1'b1);
   endtask
   task automatic wait_rx(input logic [31:0] exp, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 600 && !ok; i++) begin
         tick(1);
         ok = (rx_valid === 1'b1 && rx_frame === exp);
      end
   endtask
   task automatic wait_tx(input logic [31:0] exp, output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 600 && !ok; i++) begin
         tick(1);
         ok = (got === exp);
      end
   endtask
   task automatic t_default();
      check({bclk_oe, frame_pulse_oe}, 2'b00);
   endtask
   task automatic t_slave(input tia_fmt_type f, input logic [31:0] wr, input logic [31:0] wt);
      logic ok;
      cfg = '{fmt: f, master: 1'b0};
      echo = 1'b0;
      src = wr;
      run = 1'b1;
      // A whole frame passes first, so the port has locked to the far side's
      // framing before a word is queued; an early word could go out cut.
      tick(16);
      check({bclk_oe, frame_pulse_oe}, 2'b00);
      send(wt);
      wait_tx(wt, ok);
      check(ok, 1'b1);
      wait_rx(wr, ok);
      check(ok, 1'b1);
   endtask
   task automatic t_master(input tia_fmt_type f, input logic [31:0] w);
      logic ok;
      run = 1'b0;
      echo = 1'b1;
      tick(4);
      cfg = '{fmt: f, master: 1'b1};
      tick(2);
      check({bclk_oe, frame_pulse_oe, pcm_tx_data_oe}, 3'b111);
      send(w);
      wait_rx(w, ok);
      check(ok, 1'b1);
   endtask
   task automatic t_reset();
      device_rst_n = 1'b0;
      tick(4);
      check({bclk_oe, frame_pulse_oe, pcm_tx_data_oe}, 3'b000);
      check(bclk_pin, 1'b0);
      cfg = CFG_RESET;
      device_rst_n = 1'b1;
      tick(6);
      check({bclk_oe, frame_pulse_oe}, 2'b00);
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 30000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      tick(3);
      srst = 1'b0;
      tick(4);
      t_default();
      t_slave(TIA_FMT_I2S, 32'hA5C3_3C5A, 32'h8001_7FFE);
      t_slave(TIA_FMT_PCM, 32'h1234_FEDC, 32'hC0DE_0F0F);
      t_master(TIA_FMT_PCM, 32'h9ABC_5555);
      t_master(TIA_FMT_I2S, 32'hF00D_1234);
      t_reset();
      t_slave(TIA_FMT_I2S, 32'h0FF0_8421, 32'h7E81_3CC3);
      end_of_test();
   end
endmodule
`default_nettype wire

// *** verif/tia_far_end.sv ***
// Behavioural far-side converter: bit clock and framing master, capture of device data.
`timescale 1ns/1ps
`default_nettype none
module tia_far_end (
   input  wire logic        clk_link,
   input  wire logic        run,
   input  wire logic        fmt_pcm,
   input  wire logic [31:0] src,
   input  wire logic        bclk_pin,
   input  wire logic        dev_sdo,
   output logic             bclk_out,
   output logic             fs_line,
   output logic             sdi,
   output logic [31:0]      got
);
   logic [4:0]  cnt  = 5'h00;
   logic [4:0]  nxt;
   logic [31:0] sh   = 32'h0;
   logic [31:0] got_q = 32'h0;
   logic        fs_q = 1'b0;
   logic        sd_q = 1'b0;
   assign nxt = cnt + 5'h01;
   assign got = got_q;
   assign sdi = sd_q;
   // The clock is gated low when stopped, so the pad rests at the pull-down level in reset.
   assign bclk_out = run & clk_link;
   // A released select line shows the inverse of its last level, never a stale copy.
   assign fs_line = run ? fs_q : ~fs_q;
   always @(negedge bclk_pin) begin
      cnt  <= nxt;
      fs_q <= fmt_pcm ? (nxt == 5'h1F) : (nxt >= 5'h0F && nxt <= 5'h1E);
      sd_q <= src[5'h1F - nxt];
   end
   always @(posedge bclk_pin) begin
      sh <= {sh[30:0], dev_sdo};
      if (cnt == 5'h1F) got_q <= {sh[30:0], dev_sdo};
   end
endmodule
`default_nettype wire

// *** verilog/tia_audio_port.sv ***
// Shared serial audio port: PCM/TDM or I2S framing, master or slave.
// Function
// - While device reset is low, port stays idle and every pin driver is released; link logic resets only on a running bit clock.
// - In PCM/TDM the bit clock carries exactly one data bit per period.
// - TDM master drives the bit clock; TDM slave takes it as an input.
// - I2S master drives the bit clock; I2S slave takes it from the master.
// - After power-up both clock and frame pins are inputs, as I2S slave.
// - In PCM/TDM the frame pulse aligns the start of each frame.
// - PCM slave follows external frame pulse; PCM master generates and drives it.
// - I2S word select marks left/right; master drives it, slave accepts it.
// - Serial audio enters on the data-in pin and leaves on data-out.
// - One physical port shared by both framings, only one active at once.
`timescale 1ns/1ps
`default_nettype none
module tia_audio_port
   import tia_pkg::*;
#(
   parameter int BCLK_HALF_CYC = BCLK_HALF
) (
   input  wire logic          clk_sys,
   input  wire logic          srst,
   input  wire logic          device_rst_n,
   input  var  tia_cfg_type   cfg,
   input  var  tia_frame_type tx_frame,
   input  wire logic          tx_valid,
   output logic               tx_ready,
   output tia_frame_type      rx_frame,
   output logic               rx_valid,
   input  wire logic          bclk,
   output logic               bclk_drv,
   output logic               bclk_oe,
   input  wire logic          frame_pulse,
   output logic               frame_pulse_drv,
   output logic               frame_pulse_oe,
   input  wire logic          pcm_rx_data,
   output logic               pcm_tx_data,
   output logic               pcm_tx_data_oe
);
   if (BCLK_HALF_CYC < 1 || BCLK_HALF_CYC > (1 << DIV_W)) begin : g_div_check
      $error("BCLK_HALF_CYC out of range");
   end

   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BCLK_HALF_CYC - 1);

   // System domain state.
   logic          rst_n_s;
   logic          active_q,     active_d;
   tia_cfg_type   cfg_q,        cfg_d;
   logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
   logic          bclk_q,       bclk_d;
   logic          bclk_oe_q,    bclk_oe_d;
   logic          fp_oe_q,      fp_oe_d;
   logic          tx_oe_q,      tx_oe_d;
   tia_frame_type tx_hold_q,    tx_hold_d;
   logic          tx_req_q,     tx_req_d;
   logic          tx_ack_s;
   logic          rx_tgl_s;
   logic          rx_seen_q,    rx_seen_d;
   tia_frame_type rx_frame_q,   rx_frame_d;
   logic          rx_valid_q,   rx_valid_d;
   logic          master_run;

   // Link domain state.
   logic          lrst;
   tia_cfg_type   lcfg;
   logic          tx_req_s;
   logic [CNT_W-1:0] cnt_q,     cnt_d;
   logic          ws_prev_q,    ws_prev_d;
   logic          mark;
   logic [FRAME_BITS-1:0] rx_shift_q, rx_shift_d;
   tia_frame_type rx_hold_q,    rx_hold_d;
   logic          rx_tgl_q,     rx_tgl_d;
   logic [FRAME_BITS-1:0] tx_shift_q, tx_shift_d;
   logic [FRAME_BITS-1:0] tx_load;
   logic          sdo_q,        sdo_d;
   logic          fp_drv_q,     fp_drv_d;
   logic          tx_ack_q,     tx_ack_d;

   // The reset pin is asynchronous to clk_sys and is synchronised first.
   tia_sync2 #(.W(1)) u_rst_sync (
      .clk (clk_sys),
      .rst (srst),
      .d   (device_rst_n),
      .q   (rst_n_s)
   );

   tia_sync2 #(.W(1)) u_ack_sync (
      .clk (clk_sys),
      .rst (srst),
      .d   (tx_ack_q),
      .q   (tx_ack_s)
   );

   tia_sync2 #(.W(1)) u_rxt_sync (
      .clk (clk_sys),
      .rst (srst),
      .d   (rx_tgl_q),
      .q   (rx_tgl_s)
   );

   // Link reset follows the port's idle state; a stopped bit clock keeps the
   // link logic frozen, which is harmless because the pins are released then.
   tia_sync2 #(.W(1)) u_lrst_sync (
      .clk (bclk),
      .rst (1'b0),
      .d   (~active_q),
      .q   (lrst)
   );

   tia_sync2 #(.W(2)) u_cfg_sync (
      .clk (bclk),
      .rst (lrst),
      .d   (cfg_q),
      .q   (lcfg)
   );

   tia_sync2 #(.W(1)) u_req_sync (
      .clk (bclk),
      .rst (lrst),
      .d   (tx_req_q),
      .q   (tx_req_s)
   );

   assign master_run = active_q & cfg_q.master;

   always_comb begin
      active_d   = ~srst & rst_n_s;
      cfg_d      = cfg_q;
      if (srst || !rst_n_s) begin
         cfg_d = CFG_RESET;
      end else if (cfg != cfg_q) begin
         cfg_d = cfg;
      end
      div_cnt_d  = div_cnt_q + DIV_W'(1);
      bclk_d     = bclk_q;
      if (!master_run) begin
         div_cnt_d = '0;
         bclk_d    = 1'b0;
      end else if (div_cnt_q == DIV_LAST) begin
         div_cnt_d = '0;
         bclk_d    = ~bclk_q;
      end
      bclk_oe_d  = active_d & cfg_d.master;
      fp_oe_d    = active_d & cfg_d.master;
      tx_oe_d    = active_d;
      tx_hold_d  = tx_hold_q;
      tx_req_d   = tx_req_q;
      if (tx_valid && tx_ready) begin
         tx_hold_d = tx_frame;
         tx_req_d  = ~tx_req_q;
      end
      rx_seen_d  = rx_tgl_s;
      rx_valid_d = active_q & (rx_tgl_s != rx_seen_q);
      rx_frame_d = rx_valid_d ? rx_hold_q : rx_frame_q;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         active_q   <= 1'b0;
         cfg_q      <= CFG_RESET;
         div_cnt_q  <= '0;
         bclk_q     <= 1'b0;
         bclk_oe_q  <= 1'b0;
         fp_oe_q    <= 1'b0;
         tx_oe_q    <= 1'b0;
         tx_hold_q  <= '0;
         tx_req_q   <= 1'b0;
         rx_seen_q  <= 1'b0;
         rx_frame_q <= '0;
         rx_valid_q <= 1'b0;
      end else begin
         active_q   <= active_d;
         cfg_q      <= cfg_d;
         div_cnt_q  <= div_cnt_d;
         bclk_q     <= bclk_d;
         bclk_oe_q  <= bclk_oe_d;
         fp_oe_q    <= fp_oe_d;
         tx_oe_q    <= tx_oe_d;
         tx_hold_q  <= tx_hold_d;
         tx_req_q   <= tx_req_d;
         rx_seen_q  <= rx_seen_d;
         rx_frame_q <= rx_frame_d;
         rx_valid_q <= rx_valid_d;
      end
   end

   // Only one frame may wait for the link; the held word stays stable until
   // the link acknowledges it, so the link may read it without a synchroniser.
   assign tx_ready        = active_q & (tx_req_q == tx_ack_s);
   assign rx_frame        = rx_frame_q;
   assign rx_valid        = rx_valid_q;
   assign bclk_drv        = bclk_q;
   assign bclk_oe         = bclk_oe_q;
   assign frame_pulse_drv = fp_drv_q;
   assign frame_pulse_oe  = fp_oe_q;
   assign pcm_tx_data     = sdo_q;
   assign pcm_tx_data_oe  = tx_oe_q;

   // The frame pin is always read back from the pad, so a master follows its
   // own pulse exactly as a slave follows the external one.
   always_comb begin
      if (lcfg.fmt == TIA_FMT_PCM) begin
         mark = frame_pulse;
      end else begin
         mark = ws_prev_q & ~frame_pulse;
      end
      ws_prev_d  = frame_pulse;
      cnt_d      = (mark || cnt_q == CNT_LAST) ? CNT_FIRST : cnt_q + CNT_W'(1);
      rx_shift_d = {rx_shift_q[FRAME_BITS-2:0], pcm_rx_data};
      rx_hold_d  = rx_hold_q;
      rx_tgl_d   = rx_tgl_q;
      if (cnt_q == CNT_LAST) begin
         rx_hold_d = rx_shift_d;
         rx_tgl_d  = ~rx_tgl_q;
      end
   end

   always_ff @(posedge bclk) begin
      if (lrst) begin
         cnt_q      <= CNT_FIRST;
         ws_prev_q  <= 1'b0;
         rx_shift_q <= '0;
         rx_hold_q  <= '0;
         rx_tgl_q   <= 1'b0;
      end else begin
         cnt_q      <= cnt_d;
         ws_prev_q  <= ws_prev_d;
         rx_shift_q <= rx_shift_d;
         rx_hold_q  <= rx_hold_d;
         rx_tgl_q   <= rx_tgl_d;
      end
   end

   // Data and frame outputs change on the falling edge so that the far end
   // samples them mid-bit on the rising edge. Missing words send silence.
   always_comb begin
      tx_ack_d = tx_ack_q;
      tx_load  = '0;
      if (tx_req_s != tx_ack_q) begin
         tx_load = tx_hold_q;
      end
      if (cnt_q == CNT_FIRST) begin
         if (tx_req_s != tx_ack_q) begin
            tx_ack_d = ~tx_ack_q;
         end
         sdo_d      = tx_load[FRAME_BITS-1];
         tx_shift_d = {tx_load[FRAME_BITS-2:0], 1'b0};
      end else begin
         sdo_d      = tx_shift_q[FRAME_BITS-1];
         tx_shift_d = {tx_shift_q[FRAME_BITS-2:0], 1'b0};
      end
      if (lcfg.fmt == TIA_FMT_PCM) begin
         fp_drv_d = (cnt_q == CNT_LAST);
      end else begin
         fp_drv_d = (cnt_q >= CNT_HALF - CNT_W'(1)) && (cnt_q != CNT_LAST);
      end
   end

   always_ff @(negedge bclk) begin
      if (lrst) begin
         tx_shift_q <= '0;
         sdo_q      <= 1'b0;
         fp_drv_q   <= 1'b0;
         tx_ack_q   <= 1'b0;
      end else begin
         tx_shift_q <= tx_shift_d;
         sdo_q      <= sdo_d;
         fp_drv_q   <= fp_drv_d;
         tx_ack_q   <= tx_ack_d;
      end
   end

   hiz_in_reset_a: assert property (
      @(posedge clk_sys) disable iff (srst)
      !rst_n_s |=> !bclk_oe && !frame_pulse_oe && !pcm_tx_data_oe)
      else $error("pin driven while device reset is low");

   boot_as_slave_a: assert property (
      @(posedge clk_sys) srst |=> !bclk_oe && !frame_pulse_oe && cfg_q == CFG_RESET)
      else $error("port not an I2S slave after reset");

   master_drives_a: assert property (
      @(posedge clk_sys) disable iff (srst)
      active_q && cfg_q.master |-> bclk_oe && frame_pulse_oe)
      else $error("master does not drive clock and frame");

   slave_listens_a: assert property (
      @(posedge clk_sys) disable iff (srst)
      !cfg_q.master |-> !bclk_oe && !frame_pulse_oe)
      else $error("slave drives clock or frame");

   cfg_steady_a: assert property (
      @(posedge clk_sys) disable iff (srst)
      rst_n_s && cfg == cfg_q |=> $stable(cfg_q) && $stable(bclk_oe))
      else $error("configuration moved without a change");

   bclk_period_a: assert property (
      @(posedge clk_sys) disable iff (srst)
      master_run && $past(master_run) && $changed(bclk_q) |-> $past(div_cnt_q) == DIV_LAST)
      else $error("bit clock half period wrong");

   frame_align_a: assert property (
      @(posedge bclk) disable iff (lrst)
      mark |=> cnt_q == CNT_FIRST)
      else $error("frame marker did not restart the bit count");

   one_bit_step_a: assert property (
      @(posedge bclk) disable iff (lrst)
      !mark && cnt_q != CNT_LAST |=> cnt_q == $past(cnt_q) + CNT_W'(1))
      else $error("bit count skipped a bit");

   rx_capture_a: assert property (
      @(posedge bclk) disable iff (lrst)
      cnt_q == CNT_LAST |=> rx_hold_q[0] == $past(pcm_rx_data) && rx_tgl_q != $past(rx_tgl_q))
      else $error("received frame not captured");

   pcm_pulse_a: assert property (
      @(posedge bclk) disable iff (lrst)
      lcfg.fmt == TIA_FMT_PCM && fp_drv_q |-> cnt_q == CNT_LAST)
      else $error("frame pulse out of place");
endmodule
`default_nettype wire

// *** verilog/tia_pkg.sv ***
// Shared constants and types of the shared PCM/TDM and I2S serial audio port.
package tia_pkg;
   localparam int WORD_W     = 16;
   localparam int FRAME_BITS = 2 * WORD_W;
   localparam int CNT_W      = $clog2(FRAME_BITS);
   localparam logic [CNT_W-1:0] CNT_FIRST = CNT_W'(0);
   localparam logic [CNT_W-1:0] CNT_HALF  = CNT_W'(WORD_W);
   localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(FRAME_BITS - 1);
   localparam int CLK_SYS_HZ = 25_000_000;
   localparam int BCLK_HZ    = 3_125_000;
   localparam int BCLK_HALF  = CLK_SYS_HZ / (2 * BCLK_HZ);
   localparam int DIV_W      = 8;

   typedef enum logic {
      TIA_FMT_I2S = 1'b0,
      TIA_FMT_PCM = 1'b1
   } tia_fmt_type;

   typedef struct packed {
      tia_fmt_type fmt;
      logic        master;
   } tia_cfg_type;

   localparam tia_cfg_type CFG_RESET = '{fmt: TIA_FMT_I2S, master: 1'b0};

   typedef struct packed {
      logic [WORD_W-1:0] left;
      logic [WORD_W-1:0] right;
   } tia_frame_type;
endpackage

// *** verilog/tia_sync2.sv ***
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
`default_nettype none
module tia_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   always_comb begin
      meta_d = rst ? '0 : d;
      q_d    = rst ? '0 : meta_q;
   end

   always_ff @(posedge clk) begin
      meta_q <= meta_d;
      q      <= q_d;
   end
endmodule
`default_nettype wire
